/* File: hdl/sarcc_coder.sv */
// output coding of the raw approximation word
`timescale 1ns/1ps
`include "sarcc_params.svh"
module sarcc_coder import sarcc_pkg::*; #(
	parameter int DW = `SARCC_DATA_W
) (
	input wire logic [DW-1:0] raw_i,
	input wire logic [2:0] incc_i,
	output logic bipolar_o,
	output logic [DW-1:0] code_o
);

	// ----------------------------------------
	// range decode and coding
	// ----------------------------------------
	// 00x and 010 are bipolar; 011 is unlisted and kept straight binary
	always_comb begin
		bipolar_o = ~incc_i[2] & ~(incc_i[1] & incc_i[0]);
		code_o = raw_i;
		if (bipolar_o) begin
			// offset binary to twos complement: midscale maps to zero
			code_o = {~raw_i[DW-1], raw_i[DW-2:0]};
		end
	end
	// the approximation cannot pass all-ones or all-zeros, so limits
	// land on ffff/0000 or 7fff/8000 and midscale on 8000/0000
	// with one count per lsb in both codings

endmodule : sarcc_coder

/* File: hdl/sarcc_params.svh */
// constants of the conversion controller: field positions, resets, timing
`ifndef SARCC_PARAMS_SVH
`define SARCC_PARAMS_SVH

// ----------------------------------------
// word layout
// ----------------------------------------
`define SARCC_DATA_W 16
`define SARCC_CFG_W 14
`define SARCC_INCC_MSB 12
`define SARCC_INCC_LSB 10
`define SARCC_RB_BIT 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define SARCC_CFG_RESET 14'h3FFF
`define SARCC_CODE_RESET 16'h0000

// ----------------------------------------
// timing
// ----------------------------------------
`define SARCC_CLK_NS 40
`define SARCC_T_OPEN_NS 40
`define SARCC_OPEN_CYC ((`SARCC_T_OPEN_NS + `SARCC_CLK_NS - 1) / `SARCC_CLK_NS)
`define SARCC_T_SETTLE_NS 40
`define SARCC_SETTLE_CYC ((`SARCC_T_SETTLE_NS + `SARCC_CLK_NS - 1) / `SARCC_CLK_NS)
`define SARCC_T_THRU_NS 4000
`define SARCC_THRU_CYC (`SARCC_T_THRU_NS / `SARCC_CLK_NS)

`endif

/* File: hdl/sarcc_pkg.sv */
// types shared by the conversion controller files
package sarcc_pkg;

	// ----------------------------------------
	// conversion sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		SARCC_ACQ = 3'b000,
		SARCC_OPEN = 3'b001,
		SARCC_TRIAL = 3'b010,
		SARCC_DECIDE = 3'b011,
		SARCC_DONE = 3'b100
	} sarcc_state_t;

endpackage : sarcc_pkg

/* File: hdl/sarcc_sync.sv */
// two-stage level synchroniser
`timescale 1ns/1ps
module sarcc_sync import sarcc_pkg::*; #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] safe;
	} sarcc_sync_t;

	sarcc_sync_t s_reg;
	sarcc_sync_t s_next;

	// first stage feeds the second stage only
	always_comb begin
		s_next = s_reg;
		s_next.meta = d_i;
		s_next.safe = s_reg.meta;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign q_o = s_reg.safe;

endmodule : sarcc_sync

/* File: hdl/sarcc_top.sv */
// successive-approximation conversion control and serial result port
// What this block does
// - conversion-start rising edge opens sampling switches, then disconnects arrays.
// - convert the held differential sample; later input changes are ignored.
// - decide sixteen bits one per step, most significant first.
// - after the last bit return to acquisition, publish code, drop busy.
// - conversion runs on the internal clock; serial clock not needed.
// - unipolar input configurations give straight binary results.
// - bipolar input configurations give twos complement results.
// - full scale or overrange saturates at ffff unipolar, 7fff bipolar.
// - at or below lower limit saturates at 0000 unipolar, 8000 bipolar.
// - midscale gives 8000 unipolar, 0000 bipolar; one count per lsb.
// - host shifts a 14-bit configuration word; device applies it.
// - result readable during or after conversion, optional config readback.
// - result after a conversion belongs to that conversion, no latency.
// - support full throughput and power down between conversions.
// - start input held low during conversion enables the busy indicator.
// - configuration writes accepted during and after a conversion.
// - serial data moves most significant bit first both ways.
// - input field 010 and 00x bipolar; 111, 110, 10x unipolar.
`timescale 1ns/1ps
`include "sarcc_params.svh"
module sarcc_top import sarcc_pkg::*; #(
	parameter int DW = `SARCC_DATA_W,
	parameter int OPEN_CYC = `SARCC_OPEN_CYC,
	parameter int SETTLE_CYC = `SARCC_SETTLE_CYC
) (
	input wire logic CORE_CLK_I,
	input wire logic SRST_I,
	input wire logic CONVERSION_START_INPUT_I,
	input wire logic COMP_I,
	input wire logic SCK_I,
	input wire logic DIN_I,
	output logic SDO_O,
	output logic BUSY_O,
	output logic BUSY_IND_O,
	output logic POWER_UP_O,
	output logic POSITIVE_SAMPLING_SWITCH_O,
	output logic NEGATIVE_SAMPLING_SWITCH_O,
	output logic ARRAY_TO_INPUT_O,
	output logic [DW-1:0] DAC_CODE_O,
	output logic [DW-1:0] RESULT_O,
	output logic RESULT_VALID_O,
	output logic [`SARCC_CFG_W-1:0] CFG_O,
	output logic BIPOLAR_O
);

	// ----------------------------------------
	// sizes and elaboration checks
	// ----------------------------------------
	localparam int CW = `SARCC_CFG_W;
	localparam int FW = DW + 16;
	localparam int IW = $clog2(DW);
	localparam logic [3:0] OPEN_LAST = 4'(OPEN_CYC - 1);
	localparam logic [3:0] SETTLE_LAST = 4'(SETTLE_CYC - 1);
	localparam logic [4:0] LAST_PLAIN = 5'(DW - 1);
	localparam logic [4:0] LAST_RB = 5'(FW - 1);
	localparam logic [4:0] CFG_LAST = 5'(CW - 1);
	localparam int CONV_CYC = OPEN_CYC + DW * (SETTLE_CYC + 1) + 1;

	// frame counter is five bits and the word must hold the config
	if (DW < CW || DW > 16) begin : g_bad_width
		$error("sarcc_top: DW must lie between 14 and 16");
	end
	if (OPEN_CYC < 1 || OPEN_CYC > 16 || SETTLE_CYC < 1 || SETTLE_CYC > 16) begin : g_bad_time
		$error("sarcc_top: phase counts must lie between 1 and 16");
	end
	// the whole conversion has to fit in one throughput period
	if (CONV_CYC > `SARCC_THRU_CYC) begin : g_bad_rate
		$error("sarcc_top: conversion longer than throughput period");
	end

	// ----------------------------------------
	// core domain state
	// ----------------------------------------
	typedef struct packed {
		sarcc_state_t state;
		logic [3:0] wait_cnt;
		logic [IW-1:0] bit_idx;
		logic [DW-1:0] sar;
		logic [DW-1:0] result;
		logic [DW-1:0] tx_res;
		logic [CW-1:0] tx_cfg;
		logic [CW-1:0] cfg_pend;
		logic [CW-1:0] cfg_act;
		logic cfg_tgl_seen;
		logic cnv_prev;
		logic busy;
		logic busy_ind;
		logic sw_closed;
		logic arr_conn;
		logic pwr;
		logic valid;
	} sarcc_core_t;

	// ----------------------------------------
	// link domain state
	// ----------------------------------------
	typedef struct packed {
		logic [4:0] cnt;
		logic [FW-1:0] sh;
		logic [CW-1:0] cfg_in;
		logic [CW-1:0] cfg_word;
		logic cfg_tgl;
	} sarcc_link_t;

	sarcc_core_t c_reg;
	sarcc_core_t c_next;
	sarcc_link_t l_reg;
	sarcc_link_t l_next;

	logic cnv_s;
	logic cfg_tgl_s;
	logic link_rst;
	logic [DW-1:0] coded;
	logic bipolar_act;
	logic bipolar_pend;
	logic [DW-1:0] unused_code;
	logic [FW-1:0] frame_word;
	logic [4:0] frame_last;

	// ----------------------------------------
	// crossings
	// ----------------------------------------
	// start pin is asynchronous to the core clock; kept out of reset so a pin
	// parked high during reset does not look like a fresh edge afterwards
	sarcc_sync #(
		.W(1)
	) u_cnv_sync (
		.clk_i(CORE_CLK_I),
		.rst_i(1'b0),
		.d_i(CONVERSION_START_INPUT_I),
		.q_o(cnv_s)
	);

	// config-written event, toggled in the link domain
	sarcc_sync #(
		.W(1)
	) u_cfg_sync (
		.clk_i(CORE_CLK_I),
		.rst_i(SRST_I),
		.d_i(l_reg.cfg_tgl),
		.q_o(cfg_tgl_s)
	);

	// reset reaches the link logic only while the serial clock runs
	sarcc_sync #(
		.W(1)
	) u_rst_sync (
		.clk_i(SCK_I),
		.rst_i(1'b0),
		.d_i(SRST_I),
		.q_o(link_rst)
	);

	// ----------------------------------------
	// output coding
	// ----------------------------------------
	// coding follows the config that the conversion was started with
	sarcc_coder #(
		.DW(DW)
	) u_coder (
		.raw_i(c_reg.sar),
		.incc_i(c_reg.cfg_act[`SARCC_INCC_MSB:`SARCC_INCC_LSB]),
		.bipolar_o(bipolar_act),
		.code_o(coded)
	);

	// range of the pending config, shown to the analog front end
	sarcc_coder #(
		.DW(DW)
	) u_range (
		.raw_i(c_reg.sar),
		.incc_i(c_reg.cfg_pend[`SARCC_INCC_MSB:`SARCC_INCC_LSB]),
		.bipolar_o(bipolar_pend),
		.code_o(unused_code)
	);

	// ----------------------------------------
	// conversion sequencer
	// ----------------------------------------
	// runs only on the core clock, never on the serial clock
	always_comb begin
		c_next = c_reg;
		c_next.cnv_prev = cnv_s;
		c_next.valid = 1'b0;
		c_next.cfg_tgl_seen = cfg_tgl_s;
		// new config word taken in any state, converting or not
		if (cfg_tgl_s != c_reg.cfg_tgl_seen) begin
			c_next.cfg_pend = l_reg.cfg_word;
		end
		case (c_reg.state)
			SARCC_ACQ: begin
				c_next.sw_closed = 1'b1;
				c_next.arr_conn = 1'b1;
				c_next.pwr = 1'b0;
				if (cnv_s && !c_reg.cnv_prev) begin
					// switches open first; arrays follow after the hold time
					c_next.sw_closed = 1'b0;
					c_next.pwr = 1'b1;
					c_next.busy = 1'b1;
					c_next.cfg_act = c_reg.cfg_pend;
					c_next.wait_cnt = OPEN_LAST;
					c_next.state = SARCC_OPEN;
				end
			end
			SARCC_OPEN: begin
				if (c_reg.wait_cnt == 4'h0) begin
					// sample is now held on the arrays alone
					c_next.arr_conn = 1'b0;
					c_next.bit_idx = IW'(DW - 1);
					c_next.sar = '0;
					c_next.sar[DW-1] = 1'b1;
					c_next.wait_cnt = SETTLE_LAST;
					c_next.state = SARCC_TRIAL;
				end else begin
					c_next.wait_cnt = c_reg.wait_cnt - 4'h1;
				end
			end
			SARCC_TRIAL: begin
				// give the comparator time to settle on the trial code
				if (c_reg.wait_cnt == 4'h0) begin
					c_next.state = SARCC_DECIDE;
				end else begin
					c_next.wait_cnt = c_reg.wait_cnt - 4'h1;
				end
			end
			SARCC_DECIDE: begin
				// comparator low means the trial overshot the sample
				if (!COMP_I) begin
					c_next.sar[c_reg.bit_idx] = 1'b0;
				end
				if (c_reg.bit_idx == '0) begin
					c_next.state = SARCC_DONE;
				end else begin
					c_next.bit_idx = c_reg.bit_idx - IW'(1);
					c_next.sar[c_reg.bit_idx - IW'(1)] = 1'b1;
					c_next.wait_cnt = SETTLE_LAST;
					c_next.state = SARCC_TRIAL;
				end
			end
			SARCC_DONE: begin
				// code and readback word belong to this very conversion
				c_next.result = coded;
				c_next.tx_res = coded;
				c_next.tx_cfg = c_reg.cfg_act;
				c_next.valid = 1'b1;
				c_next.busy = 1'b0;
				c_next.sw_closed = 1'b1;
				c_next.arr_conn = 1'b1;
				c_next.pwr = 1'b0;
				c_next.state = SARCC_ACQ;
			end
			default: begin
				c_next.state = SARCC_ACQ;
			end
		endcase
		// indicator only while the host keeps the start input low
		c_next.busy_ind = c_next.busy & ~cnv_s;
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			c_reg.state <= SARCC_ACQ;
			c_reg.wait_cnt <= 4'h0;
			c_reg.bit_idx <= '0;
			c_reg.sar <= '0;
			c_reg.result <= DW'(`SARCC_CODE_RESET);
			c_reg.tx_res <= DW'(`SARCC_CODE_RESET);
			c_reg.tx_cfg <= `SARCC_CFG_RESET;
			c_reg.cfg_pend <= `SARCC_CFG_RESET;
			c_reg.cfg_act <= `SARCC_CFG_RESET;
			c_reg.cfg_tgl_seen <= 1'b0;
			c_reg.cnv_prev <= 1'b1; // no edge can be seen in the first cycle out of reset
			c_reg.busy <= 1'b0;
			c_reg.busy_ind <= 1'b0;
			c_reg.sw_closed <= 1'b1;
			c_reg.arr_conn <= 1'b1;
			c_reg.pwr <= 1'b0;
			c_reg.valid <= 1'b0;
		end else begin
			c_reg <= c_next;
		end
	end

	// ----------------------------------------
	// serial frame, link clock domain
	// ----------------------------------------
	// tx words change only at the end of a conversion, so a frame must
	// not straddle that moment; config readback doubles the frame
	assign frame_word = {c_reg.tx_res, c_reg.tx_cfg, 2'b00};
	assign frame_last = c_reg.tx_cfg[`SARCC_RB_BIT] ? LAST_PLAIN : LAST_RB;

	always_comb begin
		l_next = l_reg;
		// load on the first edge, then shift out msb first
		if (l_reg.cnt == 5'h00) begin
			l_next.sh = frame_word << 1;
		end else begin
			l_next.sh = l_reg.sh << 1;
		end
		// config bits arrive msb first on the first edges of a frame
		if (l_reg.cnt < 5'(CW)) begin
			l_next.cfg_in = {l_reg.cfg_in[CW-2:0], DIN_I};
		end
		if (l_reg.cnt == CFG_LAST) begin
			l_next.cfg_word = {l_reg.cfg_in[CW-2:0], DIN_I};
			l_next.cfg_tgl = ~l_reg.cfg_tgl;
		end
		if (l_reg.cnt == frame_last) begin
			l_next.cnt = 5'h00;
		end else begin
			l_next.cnt = l_reg.cnt + 5'h01;
		end
	end

	always_ff @(posedge SCK_I) begin
		if (link_rst) begin
			l_reg.cnt <= 5'h00;
			l_reg.sh <= '0;
			l_reg.cfg_in <= '0;
			l_reg.cfg_word <= `SARCC_CFG_RESET;
			l_reg.cfg_tgl <= 1'b0;
		end else begin
			l_reg <= l_next;
		end
	end

	// msb stands before the first edge, taken straight from the tx word
	assign SDO_O = (l_reg.cnt == 5'h00) ? frame_word[FW-1] : l_reg.sh[FW-1];

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign BUSY_O = c_reg.busy;
	assign BUSY_IND_O = c_reg.busy_ind;
	assign POWER_UP_O = c_reg.pwr;
	assign POSITIVE_SAMPLING_SWITCH_O = c_reg.sw_closed;
	assign NEGATIVE_SAMPLING_SWITCH_O = c_reg.sw_closed;
	assign ARRAY_TO_INPUT_O = c_reg.arr_conn;
	assign DAC_CODE_O = c_reg.sar;
	assign RESULT_O = c_reg.result;
	assign RESULT_VALID_O = c_reg.valid;
	// front end follows the newest word for the next acquisition
	assign CFG_O = c_reg.cfg_pend;
	assign BIPOLAR_O = bipolar_pend;

endmodule : sarcc_top

/* File: testbench/sarcc_host.sv */
// host side of the serial port; clock idles low outside frames
`timescale 1ns/1ps
module sarcc_host (
	output logic sck_o,
	output logic din_o,
	input wire logic sdo_i
);
	initial begin
		sck_o = 1'b0;
		din_o = 1'b0;
	end

	// bare clock pulses, used only around reset, while it is held and just after it drops
	task automatic pulses(input int n);
		repeat (n) begin
			#24 sck_o = 1'b1;
			#24 sck_o = 1'b0;
		end
	endtask : pulses

	// len edges: config word in, result (and readback) out, both msb first
	task automatic xfer(input logic [13:0] w, input int len, output logic [31:0] r);
		r = '0;
		for (int k = len - 1; k >= 0; k--) begin
			din_o = (k >= len - 14) ? w[k-len+14] : ~din_o;
			#24 r[k] = sdo_i;
			sck_o = 1'b1;
			#24 sck_o = 1'b0;
		end
	endtask : xfer
endmodule : sarcc_host

/* File: testbench/sarcc_monitor.sv */
// concurrent checks on the conversion controller ports
`timescale 1ns/1ps
`include "sarcc_params.svh"
module sarcc_monitor #(
	parameter int DW = 16,
	parameter int OPEN_CYC = 1,
	parameter int SETTLE_CYC = 1
) (
	input wire logic CORE_CLK_I,
	input wire logic SRST_I,
	input wire logic BUSY_O,
	input wire logic BUSY_IND_O,
	input wire logic POWER_UP_O,
	input wire logic POSITIVE_SAMPLING_SWITCH_O,
	input wire logic NEGATIVE_SAMPLING_SWITCH_O,
	input wire logic ARRAY_TO_INPUT_O,
	input wire logic [DW-1:0] DAC_CODE_O,
	input wire logic [DW-1:0] RESULT_O,
	input wire logic RESULT_VALID_O,
	input wire logic [`SARCC_CFG_W-1:0] CFG_O,
	input wire logic BIPOLAR_O
);
	// ----
	// one core clock domain
	// ----
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (SRST_I);

	// switches open one cycle before the arrays let go of the inputs
	AST_OPEN_FIRST: assert property ($fell(POSITIVE_SAMPLING_SWITCH_O) |-> ARRAY_TO_INPUT_O ##1 !ARRAY_TO_INPUT_O) else $error("array left before switches opened");
	AST_ARRAY_OPEN: assert property (!ARRAY_TO_INPUT_O |-> !POSITIVE_SAMPLING_SWITCH_O && !NEGATIVE_SAMPLING_SWITCH_O) else $error("array off with a switch closed");
	AST_MSB_TRIAL: assert property ($fell(ARRAY_TO_INPUT_O) |-> DAC_CODE_O == 16'h8000) else $error("first trial is not the top bit");
	AST_CONV_LEN: assert property ($rose(BUSY_O) |-> BUSY_O [*8] ##[25:28] RESULT_VALID_O) else $error("conversion length wrong");
	AST_END_STATE: assert property (RESULT_VALID_O |-> !BUSY_O && ARRAY_TO_INPUT_O && POSITIVE_SAMPLING_SWITCH_O && !POWER_UP_O) else $error("not back in acquisition at end");
	AST_POWER_DOWN: assert property (!BUSY_O |-> !POWER_UP_O) else $error("powered while idle");
	AST_RESULT_HOLD: assert property (!RESULT_VALID_O |-> $stable(RESULT_O)) else $error("result moved without valid");
	AST_BUSY_IND: assert property (BUSY_IND_O |-> BUSY_O) else $error("busy indicator outside conversion");
	AST_CODING: assert property (BIPOLAR_O == (CFG_O[12:10] inside {3'b000, 3'b001, 3'b010})) else $error("coding decode wrong");
endmodule : sarcc_monitor

bind sarcc_top sarcc_monitor #(.DW(DW), .OPEN_CYC(OPEN_CYC), .SETTLE_CYC(SETTLE_CYC)) u_mon (
	.CORE_CLK_I(CORE_CLK_I),
	.SRST_I(SRST_I),
	.BUSY_O(BUSY_O),
	.BUSY_IND_O(BUSY_IND_O),
	.POWER_UP_O(POWER_UP_O),
	.POSITIVE_SAMPLING_SWITCH_O(POSITIVE_SAMPLING_SWITCH_O),
	.NEGATIVE_SAMPLING_SWITCH_O(NEGATIVE_SAMPLING_SWITCH_O),
	.ARRAY_TO_INPUT_O(ARRAY_TO_INPUT_O),
	.DAC_CODE_O(DAC_CODE_O),
	.RESULT_O(RESULT_O),
	.RESULT_VALID_O(RESULT_VALID_O),
	.CFG_O(CFG_O),
	.BIPOLAR_O(BIPOLAR_O)
);

/* File: testbench/sarcc_top_tb.sv */
// self-checking bench of the conversion controller
`timescale 1ns/1ps
module sarcc_top_tb;
	logic clk, srst, conversion_start_input, comp, sck, din, sdo, busy, busy_ind, pwr, swp, swn, arr, valid, bip;
	logic [15:0] dac, res, last, ex;
	logic [31:0] rd;
	logic [13:0] cfg, w, pw, used;
	logic [31:0] rng = 32'hdee0_9d2e;
	int fails = 0, checked = 0, cyc = 0, held = 0, ain = 0, val, n;
	logic c;

	sarcc_top #(.OPEN_CYC(1), .SETTLE_CYC(1)) u_dut (.CORE_CLK_I(clk), .SRST_I(srst),
		.CONVERSION_START_INPUT_I(conversion_start_input), .COMP_I(comp), .SCK_I(sck), .DIN_I(din), .SDO_O(sdo),
		.BUSY_O(busy), .BUSY_IND_O(busy_ind), .POWER_UP_O(pwr),
		.POSITIVE_SAMPLING_SWITCH_O(swp), .NEGATIVE_SAMPLING_SWITCH_O(swn),
		.ARRAY_TO_INPUT_O(arr), .DAC_CODE_O(dac), .RESULT_O(res), .RESULT_VALID_O(valid),
		.CFG_O(cfg), .BIPOLAR_O(bip));
	sarcc_host u_host (.sck_o(sck), .din_o(din), .sdo_i(sdo));

	// comparator model: held sample against the trial code
	assign comp = (held >= int'(dac));
	// sample is frozen when the switches open
	always @(negedge swp) held = ain;
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			fails++;
			report_and_stop();
		end
	end

	// ----
	// helpers
	// ----
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	// integer model of the coded result with saturation
	function automatic logic [15:0] code(input int v, input logic [13:0] cw);
		logic [15:0] r;
		r = (v < 0) ? 16'h0000 : (v > 65535) ? 16'hffff : 16'(v);
		if (cw[12:10] inside {3'b000, 3'b001, 3'b010}) r[15] = ~r[15];
		return r;
	endfunction : code
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wait_cfg(input logic [13:0] cw);
		n = 0;
		while (cfg !== cw && n < 20) begin
			tick(1);
			n++;
		end
		check(16'(cfg), 16'(cw));
	endtask : wait_cfg
	task automatic report_and_stop();
		if (fails == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : report_and_stop

	// ----
	// main sequence
	// ----
	initial begin
		srst = 1'b1;
		conversion_start_input = 1'b1;
		last = 16'h0000;
		pw = 14'h3fff;
		fork
			u_host.pulses(4);
			tick(12);
		join
		srst = 1'b0;
		// two more serial edges let the link reset drop before the first frame
		fork
			u_host.pulses(2);
			tick(3);
		join
		check(res, 16'h0000);
		check(16'(cfg), 16'h3fff);
		check(16'({busy, pwr, swp, swn, arr}), 16'h0007);
		conversion_start_input = 1'b0;
		tick(2);
		for (int i = 0; i < 24; i++) begin
			rng = xs(rng);
			c = i[3];
			w = {rng[13], 3'(i), rng[9:1], 1'b1};
			case (i)
				0: val = 0;
				1: val = 65535;
				2: val = 32768;
				3: val = 32767;
				4: val = 70000;
				5: val = -9;
				6: val = 32768;
				7: val = 32769;
				default: val = int'(rng[31:16]);
			endcase
			ain = val;
			used = c ? pw : w;
			if (!c) begin
				u_host.xfer(w, 16, rd);
				check(rd[15:0], last);
				wait_cfg(w);
				check(16'(bip), 16'(w[12:10] inside {3'b000, 3'b001, 3'b010}));
			end
			conversion_start_input = 1'b1;
			tick(2);
			conversion_start_input = i[0];
			fork
				if (c) begin
					tick(6);
					u_host.xfer(w, 16, rd);
					check(rd[15:0], last);
				end
				begin
					n = 0;
					while (busy !== 1'b1 && n < 10) begin
						tick(1);
						n++;
					end
					check(16'({busy, swp, swn}), 16'h0004);
					ain = ~val;
					tick(10);
					check(16'(busy_ind), 16'(!i[0]));
					check(16'(pwr), 16'h0001);
					n = 0;
					while (valid !== 1'b1 && n < 60) begin
						tick(1);
						n++;
					end
					check(16'(valid), 16'h0001);
					ex = code(val, used);
					check(res, ex);
				end
			join
			if (c) wait_cfg(w);
			last = ex;
			pw = w;
			conversion_start_input = 1'b0;
			tick(2);
		end
		u_host.xfer(pw, 16, rd);
		check(rd[15:0], last);
		// readback on: the frame after this conversion doubles and returns its config
		w = {rng[13], 3'b110, rng[9:1], 1'b0};
		u_host.xfer(w, 16, rd);
		check(rd[15:0], last);
		wait_cfg(w);
		val = int'(rng[31:16]);
		ain = val;
		conversion_start_input = 1'b1;
		tick(2);
		conversion_start_input = 1'b0;
		n = 0;
		while (valid !== 1'b1 && n < 60) begin
			tick(1);
			n++;
		end
		check(16'(valid), 16'h0001);
		ex = code(val, w);
		check(res, ex);
		u_host.xfer(w, 32, rd);
		check(rd[31:16], ex);
		check(rd[15:0], {w, 2'b00});
		report_and_stop();
	end
endmodule : sarcc_top_tb
